// ==== logic/stp_packer.v ====
`timescale 1ns/10ps
`include "stp_packer_regs.vh"
// Behaviour
// RULE1: Zero pack length means no length limit
// RULE2: Release when count reaches nonzero pack length
// RULE3: No delimiters: forward each byte at once
// RULE4: With delimiter, hold until sequence received
// RULE5: Zero delimiter is unused; both zero disables
// RULE6: Full 1K buffer releases and empties
// RULE7: Software must set first delimiter first
// RULE8: Two-char sequence needed; process needs first
// RULE9: No-action option releases including delimiter
// RULE10: Plus options wait one or two bytes
// RULE11: Strip option drops delimiter bytes
// RULE12: Zero force timeout waits forever
// RULE13: Force timeout releases whole buffer
// RULE14: Force timeout should exceed character time
// RULE15: Inactivity should exceed force timeout
// RULE16: Inactivity only in any-character connect mode
// RULE17: Without skip, wait for every host
// RULE18: With skip, drop a stalled host
// RULE19: Skip only when max connections above one
// RULE20: Four destination entries, each can open
// RULE21: Close link after idle serial time
// RULE22: Force timer restarts per byte, stops on release; a release made on a byte restarts it instead
module stp_packer #(
  parameter MS_CYCLES = `STP_MS_NS / `STP_CLK_NS
) (
  input wire CLOCK,
  input wire RESETN,
  input wire [3:0] ADDRESS,
  input wire READ,
  input wire WRITE,
  input wire [31:0] WRITEDATA,
  output reg [31:0] READDATA,
  output reg WAITREQUEST,
  input wire RX_VALID,
  input wire [7:0] RX_DATA,
  output reg RX_READY,
  output reg TX_VALID,
  output reg [7:0] TX_DATA,
  output reg TX_LAST,
  input wire TX_READY,
  input wire [3:0] HOST_CONN,
  input wire [3:0] HOST_DONE,
  input wire [3:0] HOST_STALL,
  output reg LINK_OPEN,
  output reg [3:0] OPEN_REQ
);
  localparam S_FILL = 2'h0;
  localparam S_SEND = 2'h1;
  localparam S_WAIT = 2'h2;

  // ==========================================
  // Configuration registers
  reg [1:0] proc_q;
  reg skip_stalled_host_q;
  reg [2:0] max_conn_q;
  reg [1:0] cmode_q;
  reg [10:0] plen_q;
  reg [7:0] d1_q;
  reg [7:0] d2_q;
  reg [15:0] force_q;
  reg [15:0] inact_q;
  reg [31:0] dest_q [0:`STP_HOSTS-1];

  // ==========================================
  // Packing state
  reg [7:0] mem [0:1023];
  reg [1:0] state_q;
  reg [10:0] cnt_q;
  reg [10:0] len_q;
  reg [10:0] rd_q;
  reg [1:0] post_q;
  reg prev_q;
  reg [3:0] pend_q;
  reg [17:0] div_q;
  reg tick_q;

  wire acc;
  wire ft_exp;
  wire in_exp;
  wire [5:0] boff;
  wire skip_en;
  wire [3:0] pend_left;
  wire tx_beat;
  reg [10:0] cnt_inc;
  reg [10:0] dlen;
  reg [10:0] len_d;
  reg [1:0] post_d;
  reg det;
  reg rel;
  reg link_d;
  integer i;
  integer j;

  assign acc = RX_VALID && RX_READY && (state_q == S_FILL);
  assign boff = {ADDRESS, 2'b00};
  assign tx_beat = TX_VALID && TX_READY;
  assign skip_en = skip_stalled_host_q && (max_conn_q > 3'h1); // [RULE19]
  assign pend_left = pend_q & ~HOST_DONE & ~(skip_en ? HOST_STALL : 4'h0); // [RULE18]

  // ==========================================
  // Millisecond enable
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      div_q <= 18'h00000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == MS_CYCLES[17:0] - 18'h00001);
      if (div_q == MS_CYCLES[17:0] - 18'h00001) begin
        div_q <= 18'h00000;
      end else begin
        div_q <= div_q + 18'h00001;
      end
    end
  end

  // Zero limit leaves the timer idle, so the buffer waits for data forever
  stp_ms_timer u_force (
    .clk(CLOCK),
    .rstn(RESETN),
    .ms_tick(tick_q),
    .restart(acc), // [RULE22] [RULE12]
    .stop(rel), // [RULE22]
    .limit(force_q),
    .expire(ft_exp)
  );

  stp_ms_timer u_inact (
    .clk(CLOCK),
    .rstn(RESETN),
    .ms_tick(tick_q),
    .restart(acc || tx_beat), // [RULE21]
    .stop(!(LINK_OPEN && cmode_q == `STP_CMODE_ANYIN)), // [RULE16]
    .limit(inact_q),
    .expire(in_exp)
  );

  // ==========================================
  // Release decision
  always @* begin
    cnt_inc = cnt_q + 11'h001;
    dlen = (d2_q == 8'h00) ? 11'h001 : 11'h002;
    det = (d1_q != 8'h00) && // [RULE5] [RULE8]
      ((d2_q == 8'h00) ? (RX_DATA == d1_q) : (prev_q && RX_DATA == d2_q)); // [RULE4]
    rel = 1'b0;
    len_d = cnt_inc;
    post_d = post_q;
    if (acc) begin
      if (post_q != 2'h0) begin
        post_d = post_q - 2'h1;
        rel = (post_q == 2'h1); // [RULE10]
      end else if (det) begin
        case (proc_q)
          `STP_PROC_NONE: rel = 1'b1; // [RULE9]
          `STP_PROC_PLUS1: post_d = 2'h1; // [RULE10]
          `STP_PROC_PLUS2: post_d = 2'h2; // [RULE10]
          `STP_PROC_STRIP: rel = 1'b1; // [RULE11]
          default: rel = 1'b1;
        endcase
      end
      if (d1_q == 8'h00) begin
        rel = 1'b1; // [RULE3]
      end
      if (plen_q != 11'h000 && cnt_inc == plen_q) begin
        rel = 1'b1; // [RULE2] [RULE1]
      end
      if (cnt_inc == `STP_BUF_BYTES) begin
        rel = 1'b1; // [RULE6]
      end
      if (det && post_q == 2'h0 && proc_q == `STP_PROC_STRIP) begin
        len_d = (cnt_inc > dlen) ? cnt_inc - dlen : 11'h000; // [RULE11]
      end
    end else if (ft_exp && cnt_q != 11'h000 && state_q == S_FILL) begin
      rel = 1'b1; // [RULE13]
      len_d = cnt_q;
    end
  end

  // ==========================================
  // Buffer, drain and host delivery
  always @(posedge CLOCK) begin
    if (acc) begin
      mem[cnt_q[9:0]] <= RX_DATA;
    end
  end

  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= S_FILL;
      cnt_q <= 11'h000;
      len_q <= 11'h000;
      rd_q <= 11'h000;
      post_q <= 2'h0;
      prev_q <= 1'b0;
      pend_q <= 4'h0;
      RX_READY <= 1'b1;
      TX_VALID <= 1'b0;
      TX_DATA <= 8'h00;
      TX_LAST <= 1'b0;
    end else begin
      case (state_q)
        S_FILL: begin
          if (acc) begin
            cnt_q <= cnt_inc;
            post_q <= post_d;
            prev_q <= (RX_DATA == d1_q);
          end
          // A release that strips to nothing just empties the buffer
          if (rel) begin
            cnt_q <= 11'h000;
            post_q <= 2'h0;
            prev_q <= 1'b0;
            len_q <= len_d;
            rd_q <= 11'h000;
            if (len_d != 11'h000) begin
              state_q <= S_SEND;
              RX_READY <= 1'b0;
            end
          end
        end
        S_SEND: begin
          if (!TX_VALID || TX_READY) begin
            if (rd_q != len_q) begin
              TX_VALID <= 1'b1;
              TX_DATA <= mem[rd_q[9:0]];
              TX_LAST <= (rd_q + 11'h001 == len_q);
              rd_q <= rd_q + 11'h001;
            end else begin
              TX_VALID <= 1'b0;
              TX_LAST <= 1'b0;
              pend_q <= HOST_CONN;
              state_q <= S_WAIT;
            end
          end
        end
        S_WAIT: begin
          // Next group is held back until every host still owed has taken it or, while skip_en is set, has stalled
          pend_q <= pend_left;
          if (pend_left == 4'h0) begin
            state_q <= S_FILL; // [RULE17]
            RX_READY <= 1'b1;
          end
        end
        default: begin
          state_q <= S_FILL;
          RX_READY <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================
  // Connection state
  // Requests follow the next link state, so none outlives a closed link
  always @* begin
    link_d = LINK_OPEN;
    if (cmode_q == `STP_CMODE_START) begin
      link_d = 1'b1;
    end else if (acc) begin
      link_d = 1'b1;
    end else if (in_exp && cmode_q == `STP_CMODE_ANYIN) begin
      link_d = 1'b0; // [RULE21] [RULE16]
    end
  end

  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      LINK_OPEN <= 1'b0;
      OPEN_REQ <= 4'h0;
    end else begin
      LINK_OPEN <= link_d;
      for (j = 0; j < `STP_HOSTS; j = j + 1) begin
        OPEN_REQ[j] <= link_d && (dest_q[j] != 32'h00000000); // [RULE20]
      end
    end
  end

  // ==========================================
  // Avalon-MM slave, one wait state per access
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      WAITREQUEST <= 1'b1;
      READDATA <= 32'h00000000;
      proc_q <= `STP_RST_PROC;
      skip_stalled_host_q <= 1'b0;
      max_conn_q <= `STP_RST_MAXC;
      cmode_q <= `STP_RST_CMODE;
      plen_q <= `STP_RST_PLEN;
      d1_q <= `STP_RST_DELIM;
      d2_q <= `STP_RST_DELIM;
      force_q <= `STP_RST_MS;
      inact_q <= `STP_RST_MS;
      for (i = 0; i < `STP_HOSTS; i = i + 1) begin
        dest_q[i] <= 32'h00000000;
      end
    end else begin
      if ((READ || WRITE) && WAITREQUEST) begin
        WAITREQUEST <= 1'b0;
        READDATA <= 32'h00000000;
        case (boff)
          `STP_OFF_CTRL: READDATA[7:0] <= {cmode_q, max_conn_q, skip_stalled_host_q, proc_q};
          `STP_OFF_PLEN: READDATA[10:0] <= plen_q;
          `STP_OFF_DELIM: READDATA[15:0] <= {d2_q, d1_q};
          `STP_OFF_FORCE: READDATA[15:0] <= force_q;
          `STP_OFF_INACT: READDATA[15:0] <= inact_q;
          `STP_OFF_STATUS: READDATA[17:0] <= {pend_q, LINK_OPEN, state_q, cnt_q};
          default: begin
            if (boff >= `STP_OFF_DEST0 && boff < `STP_OFF_DEST0 + 6'h10) begin
              READDATA <= dest_q[boff[3:2] - 2'h2];
            end
          end
        endcase
      end else begin
        WAITREQUEST <= 1'b1;
      end
      if (WRITE && !WAITREQUEST) begin
        case (boff)
          `STP_OFF_CTRL: begin
            proc_q <= WRITEDATA[`STP_CTRL_PROC];
            skip_stalled_host_q <= WRITEDATA[`STP_CTRL_SKIP];
            max_conn_q <= WRITEDATA[`STP_CTRL_MAXC];
            cmode_q <= WRITEDATA[`STP_CTRL_CMODE];
          end
          `STP_OFF_PLEN: begin
            plen_q <= (WRITEDATA[10:0] > `STP_BUF_BYTES) ? `STP_BUF_BYTES : WRITEDATA[10:0];
          end
          `STP_OFF_DELIM: begin
            d1_q <= WRITEDATA[7:0];
            d2_q <= WRITEDATA[15:8];
          end
          `STP_OFF_FORCE: force_q <= WRITEDATA[15:0];
          `STP_OFF_INACT: inact_q <= WRITEDATA[15:0];
          default: begin
            if (boff >= `STP_OFF_DEST0 && boff < `STP_OFF_DEST0 + 6'h10) begin
              dest_q[boff[3:2] - 2'h2] <= WRITEDATA;
            end
          end
        endcase
      end
    end
  end
endmodule // stp_packer

// ==== logic/stp_packer_regs.vh ====
`ifndef STP_PACKER_REGS_VH
`define STP_PACKER_REGS_VH
// ==========================================
// Register byte offsets
`define STP_OFF_CTRL 6'h00
`define STP_OFF_PLEN 6'h04
`define STP_OFF_DELIM 6'h08
`define STP_OFF_FORCE 6'h0c
`define STP_OFF_INACT 6'h10
`define STP_OFF_STATUS 6'h14
`define STP_OFF_DEST0 6'h18
// ==========================================
// Control fields
`define STP_CTRL_PROC 1:0
`define STP_CTRL_SKIP 2
`define STP_CTRL_MAXC 5:3
`define STP_CTRL_CMODE 7:6
// ==========================================
// Reset values
`define STP_RST_PROC 2'h0
`define STP_RST_MAXC 3'h1
`define STP_RST_CMODE 2'h0
`define STP_RST_PLEN 11'h000
`define STP_RST_DELIM 8'h00
`define STP_RST_MS 16'h0000
// ==========================================
// Encodings and sizes
`define STP_PROC_NONE 2'h0
`define STP_PROC_PLUS1 2'h1
`define STP_PROC_PLUS2 2'h2
`define STP_PROC_STRIP 2'h3
`define STP_CMODE_START 2'h0
`define STP_CMODE_ANY 2'h1
`define STP_CMODE_ANYIN 2'h2
`define STP_BUF_BYTES 11'h400
`define STP_HOSTS 4
// ==========================================
// Timing
`define STP_CLK_NS 5
`define STP_MS_NS 1000000
`endif

// ==== logic/stp_ms_timer.v ====
`timescale 1ns/10ps
// ==========================================
// Millisecond timeout, zero limit disables
module stp_ms_timer (
  input wire clk,
  input wire rstn,
  input wire ms_tick,
  input wire restart,
  input wire stop,
  input wire [15:0] limit,
  output reg expire
);
  reg run_q;
  reg [15:0] cnt_q;

  // Resolution is one tick, so the timeout lands between limit-1 and limit ms
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_q <= 1'b0;
      cnt_q <= 16'h0000;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (restart) begin
        run_q <= (limit != 16'h0000);
        cnt_q <= 16'h0000;
      end else if (stop) begin
        run_q <= 1'b0;
      end else if (run_q && ms_tick) begin
        if (cnt_q + 16'h0001 >= limit) begin
          expire <= 1'b1;
          run_q <= 1'b0;
        end else begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end
    end
  end
endmodule // stp_ms_timer

// ==== bench/stp_checker.sv ====
`timescale 1ns/10ps
// ==========================================
// Port checks, config mirrored from bus writes
module stp_checker (
  input wire CLOCK,
  input wire RESETN,
  input wire [3:0] ADDRESS,
  input wire WRITE,
  input wire [31:0] WRITEDATA,
  input wire WAITREQUEST,
  input wire RX_VALID,
  input wire [7:0] RX_DATA,
  input wire RX_READY,
  input wire TX_VALID,
  input wire [7:0] TX_DATA,
  input wire TX_LAST,
  input wire TX_READY,
  input wire LINK_OPEN,
  input wire [3:0] OPEN_REQ
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  logic [1:0] proc_q;
  logic [10:0] plen_q;
  logic [10:0] cnt_q;
  logic [15:0] dl_q;
  wire wr = WRITE && !WAITREQUEST;
  wire acc = RX_VALID && RX_READY;
  wire [7:0] d1 = dl_q[7:0];
  wire [7:0] d2 = dl_q[15:8];
  // Plus modes end a wait on any byte, so holds are checked outside them
  wire calm = proc_q != 2'h1 && proc_q != 2'h2;
  wire roomy = plen_q == 11'h000 && cnt_q < 11'h3ff;
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      proc_q <= 2'h0;
      plen_q <= 11'h000;
      dl_q <= 16'h0000;
      cnt_q <= 11'h000;
    end else begin
      if (wr && ADDRESS == 4'h0) proc_q <= WRITEDATA[1:0];
      if (wr && ADDRESS == 4'h1) plen_q <= WRITEDATA[10:0];
      if (wr && ADDRESS == 4'h2) dl_q <= WRITEDATA[15:0];
      cnt_q <= !RX_READY ? 11'h000 : cnt_q + {10'h000, acc};
    end
  end
  property p_fwd;
    acc && d1 == 8'h00 |=> !RX_READY ##1 TX_VALID && TX_LAST;
  endproperty
  a_fwd: assert property (p_fwd) else $error("byte not forwarded");
  property p_hold;
    acc && d1 != 8'h00 && d2 == 8'h00 && RX_DATA != d1 && calm && roomy |=> RX_READY;
  endproperty
  a_hold: assert property (p_hold) else $error("early release");
  property p_pair;
    acc && d1 != 8'h00 && d2 != 8'h00 && RX_DATA != d2 && proc_q == 2'h0 && roomy |=> RX_READY;
  endproperty
  a_pair: assert property (p_pair) else $error("pair not awaited");
  property p_rel;
    acc && d1 != 8'h00 && d2 == 8'h00 && RX_DATA == d1 && proc_q == 2'h0 |=> !RX_READY ##1 TX_VALID;
  endproperty
  a_rel: assert property (p_rel) else $error("delimiter release late");
  property p_plus;
    acc && d1 != 8'h00 && d2 == 8'h00 && RX_DATA == d1 && proc_q == 2'h2 && roomy |=> RX_READY;
  endproperty
  a_plus: assert property (p_plus) else $error("plus wait skipped");
  property p_len;
    acc && plen_q != 11'h000 && cnt_q + 11'h001 == plen_q |=> !RX_READY;
  endproperty
  a_len: assert property (p_len) else $error("length release missed");
  property p_full;
    acc && cnt_q == 11'h3ff |=> !RX_READY;
  endproperty
  a_full: assert property (p_full) else $error("full release missed");
  property p_stand;
    TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST);
  endproperty
  a_stand: assert property (p_stand) else $error("frame byte dropped");
  property p_busy;
    TX_VALID |-> !RX_READY;
  endproperty
  a_busy: assert property (p_busy) else $error("collecting while sending");
  property p_open;
    OPEN_REQ != 4'h0 |-> LINK_OPEN;
  endproperty
  a_open: assert property (p_open) else $error("open without link");
  c_last: cover property (TX_VALID && TX_READY && TX_LAST);
  c_full: cover property (acc && cnt_q == 11'h3ff);
  c_open: cover property (OPEN_REQ[0]);
endmodule // stp_checker
bind stp_packer stp_checker u_chk (.CLOCK(CLOCK), .RESETN(RESETN), .ADDRESS(ADDRESS),
  .WRITE(WRITE), .WRITEDATA(WRITEDATA), .WAITREQUEST(WAITREQUEST), .RX_VALID(RX_VALID),
  .RX_DATA(RX_DATA), .RX_READY(RX_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
  .TX_LAST(TX_LAST), .TX_READY(TX_READY), .LINK_OPEN(LINK_OPEN), .OPEN_REQ(OPEN_REQ));

// ==== bench/stp_net_model.sv ====
`timescale 1ns/10ps
// ==========================================
// Network hosts: take frame bytes, report delivery
module stp_net_model (
  input wire clk,
  input wire rstn,
  input wire slow,
  input wire [3:0] jam,
  input wire tx_valid,
  input wire [7:0] tx_data,
  input wire tx_last,
  output logic tx_ready,
  output logic [3:0] done,
  output logic [3:0] stall
);
  logic [7:0] got[$];
  logic fin_q;
  // A jammed host never reports delivery
  assign done = fin_q ? ~jam : 4'h0;
  assign stall = jam;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_ready <= 1'b0;
      fin_q <= 1'b0;
    end else begin
      tx_ready <= slow ? !tx_ready : 1'b1;
      if (tx_valid && tx_ready) begin
        got.push_back(tx_data);
        fin_q <= tx_last;
      end
    end
  end
endmodule // stp_net_model

// ==== bench/stp_packer_bench.sv ====
`timescale 1ns/10ps
// ==========================================
// Bench: bus and serial tasks, frame checks
module stp_packer_bench;
  logic CLOCK, RESETN, READ, WRITE, RX_VALID, slow;
  logic [3:0] ADDRESS, HOST_CONN, jam;
  logic [31:0] WRITEDATA, rd;
  logic [7:0] RX_DATA;
  wire [31:0] READDATA;
  wire [7:0] TX_DATA;
  wire [3:0] HOST_DONE, HOST_STALL, OPEN_REQ;
  wire WAITREQUEST, RX_READY, TX_VALID, TX_LAST, TX_READY, LINK_OPEN;
  int fail_count = 0;
  int checks_done = 0;
  stp_packer #(.MS_CYCLES(20)) u_dut (.CLOCK(CLOCK), .RESETN(RESETN), .ADDRESS(ADDRESS),
    .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .RX_READY(RX_READY),
    .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_LAST(TX_LAST), .TX_READY(TX_READY),
    .HOST_CONN(HOST_CONN), .HOST_DONE(HOST_DONE), .HOST_STALL(HOST_STALL),
    .LINK_OPEN(LINK_OPEN), .OPEN_REQ(OPEN_REQ));
  stp_net_model u_net (.clk(CLOCK), .rstn(RESETN), .slow(slow), .jam(jam),
    .tx_valid(TX_VALID), .tx_data(TX_DATA), .tx_last(TX_LAST), .tx_ready(TX_READY),
    .done(HOST_DONE), .stall(HOST_STALL));
  initial begin
    CLOCK = 1'b0;
    forever #2.5 CLOCK = !CLOCK;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      fail_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  // Request held until waitrequest is seen low, then released at that same edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    ADDRESS <= a;
    WRITEDATA <= d;
    WRITE <= w;
    READ <= !w;
    do @(posedge CLOCK); while (WAITREQUEST !== 1'b0);
    rd = READDATA;
    WRITE <= 1'b0;
    READ <= 1'b0;
  endtask
  task automatic send(input logic [7:0] b);
    @(posedge CLOCK);
    RX_VALID <= 1'b1;
    RX_DATA <= b;
    do @(posedge CLOCK); while (RX_READY !== 1'b1);
    RX_VALID <= 1'b0;
  endtask
  // Sends n bytes low first, then expects one frame of m bytes
  task automatic xfer(input int n, input logic [31:0] w, input int m, input logic [31:0] e);
    int k;
    k = 0;
    for (int i = 0; i < n; i++) send(w[8*i +: 8]);
    while (u_net.got.size() < m && k < 4000) begin
      @(posedge CLOCK);
      k++;
    end
    check(u_net.got.size(), m);
    for (int i = 0; i < m && i < 4; i++) check({24'h0, u_net.got[i]}, {24'h0, e[8*i +: 8]});
    u_net.got.delete();
  endtask
  initial begin
    repeat (20000) @(posedge CLOCK);
    fail_count++;
    final_report;
  end
  initial begin
    {RESETN, READ, WRITE, RX_VALID, slow, ADDRESS, HOST_CONN, jam, WRITEDATA, RX_DATA} = '0;
    repeat (6) @(posedge CLOCK);
    RESETN <= 1'b1;
    bus(1'b0, 4'h0, 32'h0);
    check(rd, 32'h08);
    xfer(1, 32'h5a, 1, 32'h5a);
    bus(1'b1, 4'h2, 32'h0d);
    xfer(3, 32'h0d2211, 3, 32'h0d2211);
    slow <= 1'b1;
    bus(1'b1, 4'h0, 32'h0b);
    xfer(3, 32'h0d4433, 2, 32'h4433);
    slow <= 1'b0;
    bus(1'b1, 4'h0, 32'h0a);
    xfer(4, 32'h77660d55, 4, 32'h77660d55);
    bus(1'b1, 4'h0, 32'h08);
    bus(1'b1, 4'h2, 32'h0a0d);
    xfer(4, 32'h0a0d880d, 4, 32'h0a0d880d);
    bus(1'b1, 4'h1, 32'h3);
    xfer(3, 32'h030201, 3, 32'h030201);
    bus(1'b1, 4'h1, 32'h0);
    xfer(2, 32'h9b9a, 0, 32'h0);
    repeat (100) @(posedge CLOCK);
    check(u_net.got.size(), 0);
    bus(1'b0, 4'h5, 32'h0);
    check(rd, 32'h2002);
    bus(1'b1, 4'h3, 32'h2);
    // The timer only arms on a byte, so one more byte starts the timeout
    xfer(1, 32'h9c, 3, 32'h9c9b9a);
    for (int i = 0; i < 1023; i++) send(i[7:0]);
    xfer(1, 32'hff, 1024, 32'h03020100);
    bus(1'b1, 4'h2, 32'h0);
    HOST_CONN <= 4'h3;
    jam <= 4'h2;
    xfer(1, 32'hc0, 1, 32'hc0);
    repeat (40) @(posedge CLOCK);
    check({31'h0, RX_READY}, 32'h0);
    bus(1'b1, 4'h0, 32'h0c);
    repeat (20) @(posedge CLOCK);
    check({31'h0, RX_READY}, 32'h0);
    bus(1'b1, 4'h0, 32'h14);
    repeat (20) @(posedge CLOCK);
    check({31'h0, RX_READY}, 32'h1);
    bus(1'b1, 4'h6, 32'h0a000001);
    repeat (3) @(posedge CLOCK);
    check({28'h0, OPEN_REQ}, 32'h1);
    bus(1'b1, 4'h4, 32'h4);
    bus(1'b1, 4'h0, 32'h94);
    xfer(1, 32'h31, 1, 32'h31);
    repeat (200) @(posedge CLOCK);
    check({30'h0, LINK_OPEN, |OPEN_REQ}, 32'h0);
    bus(1'b1, 4'h0, 32'h54);
    check({31'h0, LINK_OPEN}, 32'h0);
    xfer(1, 32'h32, 1, 32'h32);
    repeat (200) @(posedge CLOCK);
    check({30'h0, LINK_OPEN, OPEN_REQ[0]}, 32'h3);
    bus(1'b1, 4'hf, 32'h5);
    bus(1'b0, 4'hf, 32'h0);
    check(rd, 32'h0);
    final_report;
  end
endmodule // stp_packer_bench
